// [core/lpt_pkg.sv]
// Constants shared by the parallel port controller and its FIFO.
// Assumes a 125 MHz system clock and a 32-bit AXI4-Lite register bus.
`default_nettype none
package lpt_pkg;
	localparam int          ADDR_W        = 4;
	localparam logic [3:0]  OFF_DATA      = 4'h0;
	localparam logic [3:0]  OFF_STATUS    = 4'h4;
	localparam logic [3:0]  OFF_CTRL      = 4'h8;
	localparam logic [3:0]  OFF_FAST      = 4'hc;

	localparam int          CTRL_W        = 7;
	localparam int          CTRL_MODE     = 0;
	localparam int          CTRL_AFD      = 2;
	localparam int          CTRL_INIT     = 3;
	localparam int          CTRL_SEL      = 4;
	localparam int          CTRL_IRQEN    = 5;
	localparam int          CTRL_DIR      = 6;
	localparam logic [6:0]  CTRL_RESET    = 7'h00;

	localparam logic [1:0]  MODE_COMPAT   = 2'h0;
	localparam logic [1:0]  MODE_BIDIR    = 2'h1;
	localparam logic [1:0]  MODE_FAST     = 2'h2;

	localparam int          ST_BUSY       = 0;
	localparam int          ST_ACK_N      = 1;
	localparam int          ST_FAULT_N    = 2;
	localparam int          ST_PAPER      = 3;
	localparam int          ST_SELECTED   = 4;
	localparam int          ST_ACK_EVENT  = 5;
	localparam int          ST_EMPTY      = 6;
	localparam int          ST_FULL       = 7;
	localparam int          ST_IDLE       = 8;

	localparam int          CMD_W         = 10;
	localparam int          CMD_ADDR      = 8;
	localparam int          CMD_READ      = 9;
	localparam int          FIFO_DEPTH    = 16;

	localparam int          CLK_NS        = 8;
	localparam int          SETUP_NS      = 500;
	localparam int          STROBE_NS     = 500;
	localparam int          HOLD_NS       = 500;
	localparam int          SETUP_CYC     = (SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int          STROBE_CYC    = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int          HOLD_CYC      = (HOLD_NS + CLK_NS - 1) / CLK_NS;

	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage
`default_nettype wire

// [core/stream_if.sv]
// Valid/ready word stream between the register slave, FIFO and engine.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface stream_if #(parameter int W = 8);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// [core/word_fifo.sv]
// Synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two; storage is flip-flops.
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 16
) (
	input  wire logic mclk_i,  // System clock
	input  wire logic reset_i, // Async reset, active high
	stream_if.snk     in_s,    // Filling side
	stream_if.src     out_s,   // Draining side
	output logic      full_o,  // No room left
	output logic      empty_o  // Nothing stored
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW:0]  wr_ptr;
	logic [AW:0]  rd_ptr;
	logic         push;
	logic         pop;

	assign empty_o     = (wr_ptr == rd_ptr);
	assign full_o      = (wr_ptr[AW] != rd_ptr[AW]) &&
	                     (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	assign in_s.ready  = !full_o;
	assign out_s.valid = !empty_o;
	assign out_s.data  = mem[rd_ptr[AW-1:0]];
	assign push        = in_s.valid && !full_o;
	assign pop         = out_s.ready && !empty_o;

	always_ff @(posedge mclk_i) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= in_s.data;
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// [core/lpt_port.sv]
// Parallel port controller with an AXI4-Lite register slave.
// Assumes pins are asynchronous to mclk_i; bus master on the same clock.
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module lpt_port
	import lpt_pkg::*;
(
	input  wire logic              mclk_i,                // System clock
	input  wire logic              reset_i,               // Async reset
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,          // Write address
	input  wire logic              s_axi_awvalid,         // Write addr valid
	output logic                   s_axi_awready,         // Write addr ready
	input  wire logic [31:0]       s_axi_wdata,           // Write data
	input  wire logic [3:0]        s_axi_wstrb,           // Byte enables
	input  wire logic              s_axi_wvalid,          // Write data valid
	output logic                   s_axi_wready,          // Write data ready
	output logic [1:0]             s_axi_bresp,           // Write response
	output logic                   s_axi_bvalid,          // Response valid
	input  wire logic              s_axi_bready,          // Response ready
	input  wire logic [ADDR_W-1:0] s_axi_araddr,          // Read address
	input  wire logic              s_axi_arvalid,         // Read addr valid
	output logic                   s_axi_arready,         // Read addr ready
	output logic [31:0]            s_axi_rdata,           // Read data
	output logic [1:0]             s_axi_rresp,           // Read response
	output logic                   s_axi_rvalid,          // Read data valid
	input  wire logic              s_axi_rready,          // Read data ready
	input  wire logic [7:0]        port_data_i,           // Data pins in
	output logic [7:0]             port_data_o,           // Data pins out
	output logic                   port_data_oe_o,        // Data drive enable
	output logic                   port_direction_o,      // High for bidir-mode reads; low in fast mode
	output logic                   byte_strobe_n_o,       // Strobe / write
	output logic                   auto_feed_n_o,         // Feed / data strobe
	output logic                   peripheral_init_n_o,   // Initialize
	output logic                   peripheral_select_n_o, // Select / addr str
	input  wire logic              peripheral_ack_n_i,    // Acknowledge
	input  wire logic              peripheral_busy_i,     // Busy
	input  wire logic              peripheral_fault_n_i,  // Error
	input  wire logic              paper_out_i,           // Paper end
	input  wire logic              peripheral_selected_i, // Selected
	output logic                   irq_o                  // Interrupt request
);
	typedef enum logic [2:0] {
		S_IDLE,
		S_WAIT,
		S_SETUP,
		S_STROBE,
		S_HOLD
	} state_t;

	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		return (a == OFF_DATA) || (a == OFF_STATUS) ||
		       (a == OFF_CTRL) || (a == OFF_FAST);
	endfunction

	function automatic logic [7:0] cycles8(input int n);
		return 8'(n - 1);
	endfunction

	// Pin synchronisers: bit order {data, sel, paper, fault, busy, ack}
	logic [12:0] pin_s1;
	logic [12:0] pin_s2;
	logic [12:0] pin_s3;
	logic [12:0] pin_f;

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			pin_s1 <= 13'h0003;
			pin_s2 <= 13'h0003;
			pin_s3 <= 13'h0003;
			pin_f  <= 13'h0003;
		end else begin
			pin_s1 <= {port_data_i, peripheral_selected_i, paper_out_i,
			           peripheral_fault_n_i, peripheral_busy_i,
			           peripheral_ack_n_i};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			// A change counts once stages two and three agree
			pin_f  <= (pin_s2 & pin_s3) | (pin_f & (pin_s2 | pin_s3));
		end
	end

	logic       ack_n_f;
	logic       busy_f;
	logic [7:0] data_f;
	assign ack_n_f = pin_f[0];
	assign busy_f  = pin_f[1];
	assign data_f  = pin_f[12:5];

	// Control register
	logic [CTRL_W-1:0] ctrl;
	logic [1:0]        mode;
	logic              fast;
	logic              bidir;
	assign mode  = ctrl[CTRL_MODE+1:CTRL_MODE];
	assign fast  = (mode == MODE_FAST);
	assign bidir = (mode == MODE_BIDIR);

	logic busy_eff;
	assign busy_eff = fast ? !busy_f : busy_f;

	// Write channel
	logic              aw_have;
	logic              w_have;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0]       w_data;
	logic [3:0]        w_strb;
	logic              wr_both;
	logic              wr_push;
	logic              wr_go;

	stream_if #(.W(CMD_W)) fill_s ();
	stream_if #(.W(CMD_W)) drain_s ();

	assign s_axi_awready = !aw_have && !s_axi_bvalid;
	assign s_axi_wready  = !w_have && !s_axi_bvalid;
	assign wr_both = aw_have && w_have && !s_axi_bvalid;
	assign wr_push = w_strb[0] &&
	                 ((aw_addr == OFF_DATA) || (aw_addr == OFF_FAST));
	// Writes that feed the FIFO stall until it has room
	assign wr_go   = wr_both && (!wr_push || fill_s.ready);

	assign fill_s.valid = wr_both && wr_push;
	assign fill_s.data  = (aw_addr == OFF_FAST && w_strb[1]) ?
	                      w_data[CMD_W-1:0] : {2'b00, w_data[7:0]};

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			aw_have <= 1'b0;
			aw_addr <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_have <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			w_have <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (wr_go) begin
			w_have <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			ctrl <= CTRL_RESET;
		end else if (wr_go && aw_addr == OFF_CTRL && w_strb[0]) begin
			ctrl <= w_data[CTRL_W-1:0];
		end
	end

	// Acknowledge event, sticky; a new event beats a clear
	logic ack_prev;
	logic ack_event;
	logic ack_fall;
	assign ack_fall = ack_prev && !ack_n_f;

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			ack_prev  <= 1'b1;
			ack_event <= 1'b0;
		end else begin
			ack_prev <= ack_n_f;
			if (ack_fall) begin
				ack_event <= 1'b1;
			end else if (wr_go && aw_addr == OFF_STATUS && w_strb[0] &&
			             w_data[ST_ACK_EVENT]) begin
				ack_event <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= ack_event && ctrl[CTRL_IRQEN];
		end
	end

	// Transfer engine
	state_t           state;
	logic [7:0]       cnt;
	logic [CMD_W-1:0] cmd;
	logic [7:0]       rd_byte;
	logic             fifo_full;
	logic             fifo_empty;

	assign drain_s.ready = (state == S_IDLE);

	word_fifo #(.W(CMD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.mclk_i  (mclk_i),
		.reset_i (reset_i),
		.in_s    (fill_s),
		.out_s   (drain_s),
		.full_o  (fifo_full),
		.empty_o (fifo_empty)
	);

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			state <= S_IDLE;
			cnt   <= '0;
			cmd   <= '0;
		end else begin
			case (state)
			S_IDLE: begin
				if (drain_s.valid) begin
					cmd   <= drain_s.data;
					state <= S_WAIT;
				end
			end
			S_WAIT: begin
				if (!busy_eff) begin
					cnt   <= cycles8(SETUP_CYC);
					state <= S_SETUP;
				end
			end
			S_SETUP: begin
				if (cnt == 8'h00) begin
					cnt   <= cycles8(STROBE_CYC);
					state <= S_STROBE;
				end else begin
					cnt <= cnt - 8'h01;
				end
			end
			S_STROBE: begin
				if (cnt == 8'h00) begin
					cnt   <= cycles8(HOLD_CYC);
					state <= S_HOLD;
				end else begin
					cnt <= cnt - 8'h01;
				end
			end
			S_HOLD: begin
				if (cnt == 8'h00) begin
					state <= S_IDLE;
				end else begin
					cnt <= cnt - 8'h01;
				end
			end
			default: begin
				state <= S_IDLE;
			end
			endcase
		end
	end

	logic fast_read;
	logic engine_on;
	assign fast_read = fast && cmd[CMD_READ] && (state != S_IDLE);
	assign engine_on = (state == S_SETUP) || (state == S_STROBE) ||
	                   (state == S_HOLD);

	// Fast read: take the byte at the end of the data or address strobe
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			rd_byte <= '0;
		end else if (fast_read && state == S_STROBE && cnt == 8'h00) begin
			rd_byte <= data_f;
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			port_data_o <= '0;
		end else if (state == S_IDLE && drain_s.valid &&
		             !drain_s.data[CMD_READ]) begin
			port_data_o <= drain_s.data[7:0];
		end
	end

	// Pin outputs, registered
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			port_data_oe_o        <= 1'b1;
			port_direction_o      <= 1'b0;
			byte_strobe_n_o       <= 1'b1;
			auto_feed_n_o         <= 1'b1;
			peripheral_select_n_o <= 1'b1;
			peripheral_init_n_o   <= 1'b1;
		end else begin
			peripheral_init_n_o <= !ctrl[CTRL_INIT];
			if (fast) begin
				port_direction_o      <= 1'b0;
				port_data_oe_o        <= !fast_read;
				byte_strobe_n_o       <= !(engine_on && !cmd[CMD_READ]);
				auto_feed_n_o         <= !(state == S_STROBE &&
				                           !cmd[CMD_ADDR]);
				peripheral_select_n_o <= !(state == S_STROBE &&
				                           cmd[CMD_ADDR]);
			end else begin
				port_direction_o      <= bidir && ctrl[CTRL_DIR];
				port_data_oe_o        <= !(bidir && ctrl[CTRL_DIR]);
				byte_strobe_n_o       <= !(state == S_STROBE);
				auto_feed_n_o         <= !ctrl[CTRL_AFD];
				peripheral_select_n_o <= !ctrl[CTRL_SEL];
			end
		end
	end

	// Read channel
	logic [31:0] status_word;
	logic [7:0]  data_word;
	assign status_word = {23'h000000, (state == S_IDLE), fifo_full,
	                      fifo_empty, ack_event, pin_f[4:0]};
	always_comb begin
		if (bidir && ctrl[CTRL_DIR]) begin
			data_word = data_f;
		end else if (fast) begin
			data_word = rd_byte;
		end else begin
			data_word = port_data_o;
		end
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			case (s_axi_araddr)
			OFF_DATA:   s_axi_rdata <= {24'h000000, data_word};
			OFF_STATUS: s_axi_rdata <= status_word;
			OFF_CTRL:   s_axi_rdata <= {25'h0000000, ctrl};
			default:    s_axi_rdata <= '0;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [verification/lpt_port_sva.sv]
// Checker for lpt_port pin levels and strobe timing against its control word.
// Assumes the bus master offers a write's address and data together.
`timescale 1ns/1ps
`default_nettype none
module lpt_port_sva
	import lpt_pkg::*;
(
	input wire logic        mclk_i,                // Clock
	input wire logic        reset_i,               // Reset
	input wire logic [3:0]  s_axi_awaddr,          // Addr
	input wire logic        s_axi_awvalid,         // Addr valid
	input wire logic        s_axi_awready,         // Addr ready
	input wire logic [31:0] s_axi_wdata,           // Data
	input wire logic [3:0]  s_axi_wstrb,           // Strobes
	input wire logic        s_axi_wvalid,          // Data valid
	input wire logic        s_axi_wready,          // Data ready
	input wire logic        port_data_oe_o,        // Drive
	input wire logic        port_direction_o,      // Direction
	input wire logic        byte_strobe_n_o,       // Strobe
	input wire logic        auto_feed_n_o,         // Feed
	input wire logic        peripheral_init_n_o,   // Init
	input wire logic        peripheral_select_n_o, // Select
	input wire logic        peripheral_busy_i,     // Busy
	input wire logic        irq_o                  // Irq
);
	logic [6:0] ctrl;
	logic [2:0] age;
	logic       busy_q;
	int         low_run;
	int         busy_run;
	wire logic  fast = ctrl[1:0] == MODE_FAST;
	wire logic  bidir = ctrl[1:0] == MODE_BIDIR;
	wire logic  calm = age == 3'h7;
	wire logic  wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

	default clocking @(posedge mclk_i); endclocking
	default disable iff (reset_i);

	// Shadow control word; age lets registered outputs settle after a write
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			ctrl <= CTRL_RESET;
			age <= 3'h0;
		end else if (wr && s_axi_awaddr == OFF_CTRL && s_axi_wstrb[0]) begin
			ctrl <= s_axi_wdata[6:0];
			age <= 3'h0;
		end else if (!calm) begin
			age <= age + 3'h1;
		end
	end
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i)
			low_run <= 0;
		else if (!byte_strobe_n_o)
			low_run <= low_run + 1;
		else
			low_run <= 0;
	end
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			busy_q <= 1'b0;
			busy_run <= 0;
		end else begin
			busy_q <= peripheral_busy_i;
			if (peripheral_busy_i != busy_q)
				busy_run <= 0;
			else if (busy_run < 1000)
				busy_run <= busy_run + 1;
		end
	end

	chk_dir_level: assert property (
		calm |-> port_direction_o == (bidir && ctrl[CTRL_DIR]))
		else $error("direction level wrong");
	chk_drive_oe: assert property (
		calm && !fast |-> port_data_oe_o == !(bidir && ctrl[CTRL_DIR]))
		else $error("data drive enable wrong");
	chk_init_level: assert property (
		calm |-> peripheral_init_n_o == !ctrl[CTRL_INIT])
		else $error("init level wrong");
	chk_feed_level: assert property (
		calm && !fast |-> auto_feed_n_o == !ctrl[CTRL_AFD])
		else $error("auto feed level wrong");
	chk_irq_gate: assert property (
		calm && !ctrl[CTRL_IRQEN] |-> !irq_o)
		else $error("interrupt while disabled");
	chk_strobe_width: assert property (
		$rose(byte_strobe_n_o) && calm |->
		low_run == (fast ? SETUP_CYC + STROBE_CYC + HOLD_CYC : STROBE_CYC))
		else $error("strobe width wrong");
	chk_busy_hold: assert property (
		$fell(byte_strobe_n_o) && calm |->
		!(peripheral_busy_i == !fast && busy_run > 80))
		else $error("strobe while busy");
	chk_fast_strobes: assert property (
		fast && calm && !auto_feed_n_o |-> peripheral_select_n_o)
		else $error("address and data strobe together");
endmodule

bind lpt_port lpt_port_sva lpt_port_sva_inst (
	.mclk_i(mclk_i), .reset_i(reset_i), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.port_data_oe_o(port_data_oe_o), .port_direction_o(port_direction_o),
	.byte_strobe_n_o(byte_strobe_n_o), .auto_feed_n_o(auto_feed_n_o),
	.peripheral_init_n_o(peripheral_init_n_o),
	.peripheral_select_n_o(peripheral_select_n_o),
	.peripheral_busy_i(peripheral_busy_i), .irq_o(irq_o));
`default_nettype wire

// [verification/lpt_printer_model.sv]
// Behavioural printer on the far side of the parallel port pins.
// Assumes the bench tells it the active mode and its busy time per byte.
`timescale 1ns/1ps
`default_nettype none
module lpt_printer_model (
	input  wire logic       mclk_i,  // Clock
	input  wire logic       fast_i,  // Fast mode on
	input  wire logic [9:0] dly_i,   // Busy time
	input  wire logic [7:0] rd_i,    // Byte to return
	input  wire logic [7:0] pins_i,  // Data wire
	input  wire logic       stb_n_i, // Byte strobe
	input  wire logic       afd_n_i, // Data strobe
	input  wire logic       sel_n_i, // Address strobe
	output logic [7:0]      drv_o,   // Returned byte
	output logic            ack_n_o, // Acknowledge
	output logic            busy_o,  // Busy pin
	output logic            got_o,   // Byte latched
	output logic [7:0]      byte_o   // Latched byte
);
	logic      s_q = 1'b1;
	logic      a_q = 1'b1;
	logic      l_q = 1'b1;
	int        cnt = 0;
	wire logic take = fast_i ? !stb_n_i && ((afd_n_i && !a_q) || (sel_n_i && !l_q))
		: stb_n_i && !s_q;

	assign drv_o = rd_i;
	// Latch on the trailing edge of whichever strobe marks the write
	always @(posedge mclk_i) begin
		s_q <= stb_n_i;
		a_q <= afd_n_i;
		l_q <= sel_n_i;
		got_o <= take;
		if (take)
			byte_o <= pins_i;
		if (take)
			cnt <= dly_i + 10'd8;
		else if (cnt > 0)
			cnt <= cnt - 1;
	end
	assign busy_o = (cnt > 8) ^ fast_i;
	assign ack_n_o = !(cnt > 0 && cnt <= 8);
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench for lpt_port: register bus, FIFO, pins and printer.
// Assumes lpt_printer_model on the pins and the bound lpt_port_sva checker.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import lpt_pkg::*;
;
	logic        mclk_i, reset_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, fast, peek;
	logic        peripheral_fault_n_i, paper_out_i, peripheral_selected_i;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, v;
	logic [9:0]  dly;
	logic [7:0]  rd_b;
	logic [63:0] e64;
	wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire logic   s_axi_rvalid, port_data_oe_o, port_direction_o, irq_o, got;
	wire logic   byte_strobe_n_o, auto_feed_n_o, peripheral_init_n_o;
	wire logic   peripheral_select_n_o, peripheral_ack_n_i, peripheral_busy_i;
	wire logic [1:0]  s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic [7:0]  port_data_o, port_data_i, drv, gbyte;
	int          miscompares, n_compared, seed, i;
	logic [63:0] rq[$];
	logic [7:0]  bq[$];

	assign port_data_i = port_data_oe_o ? port_data_o : drv;
	lpt_port lpt_port_inst (.mclk_i, .reset_i, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.port_data_i, .port_data_o, .port_data_oe_o, .port_direction_o,
		.byte_strobe_n_o, .auto_feed_n_o, .peripheral_init_n_o,
		.peripheral_select_n_o, .peripheral_ack_n_i, .peripheral_busy_i,
		.peripheral_fault_n_i, .paper_out_i, .peripheral_selected_i, .irq_o);
	lpt_printer_model lpt_printer_model_inst (.mclk_i, .fast_i(fast),
		.dly_i(dly), .rd_i(rd_b), .pins_i(port_data_i), .stb_n_i(byte_strobe_n_o),
		.afd_n_i(auto_feed_n_o), .sel_n_i(peripheral_select_n_o), .drv_o(drv),
		.ack_n_o(peripheral_ack_n_i), .busy_o(peripheral_busy_i), .got_o(got),
		.byte_o(gbyte));

	initial begin
		mclk_i = 1'b0;
		forever #4 mclk_i = ~mclk_i;
	end

	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value at %0t: expected %h got %h", $time, e, g);
		end
	endtask
	task automatic wrap_up;
		$display("miscompares %0d n_compared %0d", miscompares, n_compared);
		if (miscompares == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic fail;
		miscompares++;
		wrap_up;
	endtask
	task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
		int   n;
		logic aw, w, b;
		b = 1'b0;
		@(posedge mclk_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 3000 && !b; n++) begin
			@(negedge mclk_i);
			aw = s_axi_awready;
			w = s_axi_wready;
			b = s_axi_bvalid;
			@(posedge mclk_i);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (b) s_axi_bready <= 1'b0;
		end
		if (!b) fail;
	endtask
	task automatic axr(input logic [3:0] a, output logic [31:0] d);
		int   n;
		logic t, r;
		r = 1'b0;
		@(posedge mclk_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 3000 && !r; n++) begin
			@(negedge mclk_i);
			t = s_axi_arready;
			r = s_axi_rvalid;
			d = s_axi_rdata;
			@(posedge mclk_i);
			if (t) s_axi_arvalid <= 1'b0;
			if (r) s_axi_rready <= 1'b0;
		end
		if (!r) fail;
	endtask
	task automatic expr(input logic [3:0] a, input logic [31:0] e, m);
		rq.push_back({m, e});
		axr(a, v);
	endtask
	task automatic send(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
		bq.push_back(d[7:0]);
		axw(a, d, s);
	endtask
	task automatic wait_idle;
		int n;
		peek <= 1'b1;
		v = 32'h0;
		for (n = 0; n < 400 && !(v[ST_IDLE] && v[ST_EMPTY]); n++) begin
			repeat (20) @(posedge mclk_i);
			axr(OFF_STATUS, v);
		end
		peek <= 1'b0;
		if (!(v[ST_IDLE] && v[ST_EMPTY])) fail;
	endtask

	// Takes the oldest note whenever a read answer outside wait_idle or a latched byte appears
	always @(posedge mclk_i) begin
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && peek === 1'b0) begin
			e64 = rq.pop_front();
			chk(e64[31:0], s_axi_rdata & e64[63:32]);
			chk(32'(RESP_OKAY), 32'(s_axi_rresp));
		end
		if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
			chk(32'(RESP_OKAY), 32'(s_axi_bresp));
		if (got === 1'b1)
			chk(32'(bq.pop_front()), 32'(gbyte));
	end

	initial begin
		seed = 45095;
		miscompares = 0;
		n_compared = 0;
		reset_i = 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
		{peripheral_fault_n_i, paper_out_i, peripheral_selected_i, fast, peek} = '0;
		dly = 10'd100;
		rd_b = 8'($random(seed));
		repeat (4) @(posedge mclk_i);
		reset_i <= 1'b0;
		@(negedge mclk_i);
		v = {26'h0, peripheral_init_n_o, byte_strobe_n_o, auto_feed_n_o,
			peripheral_select_n_o, port_direction_o, port_data_oe_o};
		chk(32'h3d, v);
		expr(OFF_CTRL, 32'(CTRL_RESET), 32'h7f);
		for (i = 0; i < 4; i++) begin
			@(posedge mclk_i);
			{peripheral_fault_n_i, paper_out_i, peripheral_selected_i} <= 3'($random(seed));
			repeat (12) @(posedge mclk_i);
			expr(OFF_STATUS, {27'h0, peripheral_selected_i, paper_out_i,
				peripheral_fault_n_i, 2'h0}, 32'h1c);
		end
		// Fill the FIFO behind a slow printer until a write has to wait
		axw(OFF_CTRL, 32'h24, 4'h1);
		for (i = 0; i < 18; i++) begin
			send(OFF_DATA, 32'($random(seed)) & 32'hff, 4'h1);
			if (i == 16) expr(OFF_STATUS, 32'h80, 32'hc0);
		end
		wait_idle;
		repeat (200) @(posedge mclk_i);
		@(negedge mclk_i);
		chk(32'h1, 32'(irq_o));
		axw(OFF_STATUS, 32'h20, 4'h1);
		repeat (4) @(negedge mclk_i);
		chk(32'h0, 32'(irq_o));
		axw(OFF_CTRL, 32'h08, 4'h1);
		send(OFF_DATA, 32'($random(seed)) & 32'hff, 4'h1);
		wait_idle;
		repeat (200) @(posedge mclk_i);
		@(negedge mclk_i);
		chk(32'h0, 32'(irq_o));
		expr(OFF_STATUS, 32'h20, 32'h20);
		// Expanded mode: read the printer's byte back, then write one
		axw(OFF_CTRL, 32'h41, 4'h1);
		repeat (12) @(posedge mclk_i);
		expr(OFF_DATA, {24'h0, rd_b}, 32'hff);
		axw(OFF_CTRL, 32'h01, 4'h1);
		send(OFF_DATA, 32'($random(seed)) & 32'hff, 4'h1);
		wait_idle;
		// Fast mode: data write, address write, then a read
		fast <= 1'b1;
		axw(OFF_CTRL, 32'h02, 4'h1);
		send(OFF_FAST, {24'h0, 8'($random(seed))}, 4'h3);
		send(OFF_FAST, {24'h1, 8'($random(seed))}, 4'h3);
		axw(OFF_FAST, {24'h2, 8'($random(seed))}, 4'h3);
		wait_idle;
		expr(OFF_DATA, {24'h0, rd_b}, 32'hff);
		// Mode value 3 acts as the compatible mode
		fast <= 1'b0;
		axw(OFF_CTRL, 32'h13, 4'h1);
		send(OFF_DATA, 32'($random(seed)) & 32'hff, 4'h1);
		wait_idle;
		wrap_up;
	end
endmodule
`default_nettype wire
